// *** rtl/pps_consts.vh ***
// constants of the positioning program sequencer
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH

// ----------------------------------------------------------------
// start block entry layout (16 bits)
// ----------------------------------------------------------------
`define PPS_SB_W        16
`define PPS_SB_TYPE_HI  15
`define PPS_SB_TYPE_LO  13
`define PPS_SB_PNO_HI   12
`define PPS_SB_PNO_LO   8
`define PPS_SB_ARG_HI   7
`define PPS_SB_ARG_LO   0

// start block entry types
`define PPS_T_END   3'h0
`define PPS_T_NORM  3'h1
`define PPS_T_COND  3'h2
`define PPS_T_WAIT  3'h3
`define PPS_T_SIM   3'h4
`define PPS_T_FOR   3'h5
`define PPS_T_FORC  3'h6
`define PPS_T_NEXT  3'h7

// ----------------------------------------------------------------
// positioning data entry layout (18 bits)
// ----------------------------------------------------------------
`define PPS_PD_W       18
`define PPS_PD_PAT_HI  17
`define PPS_PD_PAT_LO  16
`define PPS_PD_CNT_HI  15
`define PPS_PD_CNT_LO  0

// sequencing_pattern_field codes
`define PPS_PAT_INDEP  2'h0
`define PPS_PAT_CONT   2'h1
`define PPS_PAT_PATH   2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPS_CLK_NS     100
`define PPS_DWELL_NS   1000
`define PPS_PULSE_DIV  10

`endif

// *** rtl/pps_mem.v ***
// small synchronous memory with registered read data
`default_nettype none

module pps_mem #(
  parameter W  = 16,
  parameter AW = 5
) (
  // clock
  input  wire          i_mclk,
  // write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [W-1:0]  i_wdata,
  // read port
  input  wire [AW-1:0] i_raddr,
  output reg  [W-1:0]  o_rdata
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  // one write and one registered read per cycle
  always @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule
`default_nettype wire

// *** rtl/pps_seq.v ***
// per-axis positioning program sequencer with manual pulse output
`default_nettype none
`include "pps_consts.vh"

module pps_seq #(
  parameter AW    = 5,
  parameter NCOND = 8,
  parameter NAX   = 4,
  parameter DIV   = `PPS_PULSE_DIV
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_rst_n,
  // host requests
  input  wire             i_start,
  input  wire [AW-1:0]    i_start_blk,
  input  wire             i_stop,
  input  wire             i_hand_en,
  // start block table load
  input  wire             i_sb_we,
  input  wire [AW-1:0]    i_sb_addr,
  input  wire [15:0]      i_sb_wdata,
  // positioning data table load
  input  wire             i_pd_we,
  input  wire [AW-1:0]    i_pd_addr,
  input  wire [17:0]      i_pd_wdata,
  // pins
  input  wire [NCOND-1:0] i_cond,
  input  wire             i_feed_start,
  input  wire             i_mpg_pulse,
  // outputs to drive unit and host
  output reg              o_pulse,
  output reg              o_sim_start,
  output reg  [NAX-1:0]   o_sim_axes,
  output reg              o_busy,
  output reg              o_pos_done,
  output reg              o_done
);

  // ----------------------------------------------------------------
  // states and derived timing
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_SBRD  = 4'h1;
  localparam [3:0] S_SBDEC = 4'h2;
  localparam [3:0] S_PDRD  = 4'h3;
  localparam [3:0] S_PDDEC = 4'h4;
  localparam [3:0] S_RUN   = 4'h5;
  localparam [3:0] S_DWELL = 4'h6;
  localparam [3:0] S_FEED  = 4'h7;

  // momentary stop length, rounded down, at least one cycle
  localparam integer DWELL_RAW = `PPS_DWELL_NS / `PPS_CLK_NS;
  localparam integer DWELL_CYC = (DWELL_RAW < 1) ? 1 : DWELL_RAW;
  localparam [7:0]   DWELL_LD  = DWELL_CYC[7:0];
  localparam [7:0]   DIV_LAST  = DIV[7:0] - 8'h01;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [NCOND-1:0] cond_s1_r;
  reg [NCOND-1:0] cond_s2_r;
  reg             feed_s1_r;
  reg             feed_s2_r;
  reg             mpg_s1_r;
  reg             mpg_s2_r;
  reg             mpg_d_r;

  // two flops on every pin, edge taken only after the second
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cond_s1_r <= {NCOND{1'b0}};
      cond_s2_r <= {NCOND{1'b0}};
      feed_s1_r <= 1'b0;
      feed_s2_r <= 1'b0;
      mpg_s1_r  <= 1'b0;
      mpg_s2_r  <= 1'b0;
      mpg_d_r   <= 1'b0;
    end else begin
      cond_s1_r <= i_cond;
      cond_s2_r <= cond_s1_r;
      feed_s1_r <= i_feed_start;
      feed_s2_r <= feed_s1_r;
      mpg_s1_r  <= i_mpg_pulse;
      mpg_s2_r  <= mpg_s1_r;
      mpg_d_r   <= mpg_s2_r;
    end
  end

  wire mpg_rise = mpg_s2_r & ~mpg_d_r;

  // ----------------------------------------------------------------
  // pulse rate divider
  // ----------------------------------------------------------------
  reg  [7:0] div_cnt_r;
  wire       tick = (div_cnt_r == 8'h00);

  // free running so path transitions keep the pulse spacing
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_cnt_r <= 8'h00;
    end else if (tick) begin
      div_cnt_r <= DIV_LAST;
    end else begin
      div_cnt_r <= div_cnt_r - 8'h01;
    end
  end

  // condition lookup, shared by conditional, waiting and loop entries
  function cond_true;
    input [NCOND-1:0] flags;
    input [7:0]       arg;
    begin
      cond_true = flags[arg[2:0]];
    end
  endfunction

  // ----------------------------------------------------------------
  // tables
  // ----------------------------------------------------------------
  reg  [AW-1:0] sb_addr_r;
  reg  [AW-1:0] pd_addr_r;
  wire [15:0]   sb_q;
  wire [17:0]   pd_q;

  pps_mem #(.W(`PPS_SB_W), .AW(AW)) u_sb (
    .i_mclk  (i_mclk),
    .i_we    (i_sb_we),
    .i_waddr (i_sb_addr),
    .i_wdata (i_sb_wdata),
    .i_raddr (sb_addr_r),
    .o_rdata (sb_q)
  );

  pps_mem #(.W(`PPS_PD_W), .AW(AW)) u_pd (
    .i_mclk  (i_mclk),
    .i_we    (i_pd_we),
    .i_waddr (i_pd_addr),
    .i_wdata (i_pd_wdata),
    .i_raddr (pd_addr_r),
    .o_rdata (pd_q)
  );

  wire [2:0]    sb_type = sb_q[`PPS_SB_TYPE_HI:`PPS_SB_TYPE_LO];
  wire [AW-1:0] sb_pno  = sb_q[`PPS_SB_PNO_LO+AW-1:`PPS_SB_PNO_LO];
  wire [7:0]    sb_arg  = sb_q[`PPS_SB_ARG_HI:`PPS_SB_ARG_LO];
  wire          sb_ok   = cond_true(cond_s2_r, sb_arg);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  reg [3:0]    state_r;
  reg [15:0]   pcnt_r;
  reg [1:0]    pat_r;
  reg [7:0]    dwell_r;
  reg [7:0]    loop_cnt_r;
  reg [AW-1:0] loop_top_r;
  reg          loop_cnd_r;
  reg [7:0]    loop_arg_r;
  reg          sim_pend_r;

  // one pulse per divider tick; the last one closes the entry
  wire fire = (state_r == S_RUN) && tick && (pcnt_r != 16'h0000);

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_r     <= S_IDLE;
      sb_addr_r   <= {AW{1'b0}};
      pd_addr_r   <= {AW{1'b0}};
      pcnt_r      <= 16'h0000;
      pat_r       <= `PPS_PAT_INDEP;
      dwell_r     <= 8'h00;
      loop_cnt_r  <= 8'h00;
      loop_top_r  <= {AW{1'b0}};
      loop_cnd_r  <= 1'b0;
      loop_arg_r  <= 8'h00;
      sim_pend_r  <= 1'b0;
      o_pulse     <= 1'b0;
      o_sim_start <= 1'b0;
      o_sim_axes  <= {NAX{1'b0}};
      o_busy      <= 1'b0;
      o_pos_done  <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      // strobes last one cycle
      o_pulse     <= 1'b0;
      o_sim_start <= 1'b0;
      o_pos_done  <= 1'b0;
      o_done      <= 1'b0;
      if (i_stop && state_r != S_IDLE) begin
        state_r    <= S_IDLE;
        sim_pend_r <= 1'b0;
        o_busy     <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (i_start) begin
              sb_addr_r <= i_start_blk;
              o_busy    <= 1'b1;
              state_r   <= S_SBRD;
            end else if (feed_s2_r) begin
              o_busy  <= 1'b1;
              state_r <= S_FEED;
            end else if (i_hand_en) begin
              o_pulse <= mpg_rise;
            end
          end
          S_FEED: begin
            if (!feed_s2_r) begin
              o_busy  <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              o_pulse <= tick;
            end
          end
          S_SBRD: begin
            state_r <= S_SBDEC;
          end
          S_SBDEC: begin
            // address steps only on decisions, so a held entry re-reads itself
            case (sb_type)
              `PPS_T_END: begin
                o_busy  <= 1'b0;
                o_done  <= 1'b1;
                state_r <= S_IDLE;
              end
              `PPS_T_NORM: begin
                pd_addr_r <= sb_pno;
                state_r   <= S_PDRD;
              end
              `PPS_T_COND: begin
                if (sb_ok) begin
                  pd_addr_r <= sb_pno;
                  state_r   <= S_PDRD;
                end else begin
                  sb_addr_r <= sb_addr_r + 1'b1;
                  state_r   <= S_SBRD;
                end
              end
              `PPS_T_WAIT: begin
                if (sb_ok) begin
                  pd_addr_r <= sb_pno;
                  state_r   <= S_PDRD;
                end
              end
              `PPS_T_SIM: begin
                o_sim_axes <= sb_arg[NAX-1:0];
                sim_pend_r <= 1'b1;
                pd_addr_r  <= sb_pno;
                state_r    <= S_PDRD;
              end
              `PPS_T_FOR: begin
                // a count of zero runs the body once
                loop_cnt_r <= sb_arg;
                loop_cnd_r <= 1'b0;
                loop_top_r <= sb_addr_r + 1'b1;
                sb_addr_r  <= sb_addr_r + 1'b1;
                state_r    <= S_SBRD;
              end
              `PPS_T_FORC: begin
                loop_cnd_r <= 1'b1;
                loop_arg_r <= sb_arg;
                loop_top_r <= sb_addr_r + 1'b1;
                sb_addr_r  <= sb_addr_r + 1'b1;
                state_r    <= S_SBRD;
              end
              default: begin
                // loop close; single loop level
                state_r <= S_SBRD;
                if (loop_cnd_r) begin
                  if (cond_true(cond_s2_r, loop_arg_r)) begin
                    sb_addr_r <= sb_addr_r + 1'b1;
                  end else begin
                    sb_addr_r <= loop_top_r;
                  end
                end else if (loop_cnt_r <= 8'h01) begin
                  loop_cnt_r <= 8'h00;
                  sb_addr_r  <= sb_addr_r + 1'b1;
                end else begin
                  loop_cnt_r <= loop_cnt_r - 8'h01;
                  sb_addr_r  <= loop_top_r;
                end
              end
            endcase
          end
          S_PDRD: begin
            state_r <= S_PDDEC;
          end
          S_PDDEC: begin
            pcnt_r  <= pd_q[`PPS_PD_CNT_HI:`PPS_PD_CNT_LO];
            pat_r   <= pd_q[`PPS_PD_PAT_HI:`PPS_PD_PAT_LO];
            state_r <= S_RUN;
          end
          S_RUN: begin
            if (fire) begin
              o_pulse     <= 1'b1;
              o_sim_start <= sim_pend_r;
              sim_pend_r  <= 1'b0;
              pcnt_r      <= pcnt_r - 16'h0001;
            end
            if (pcnt_r == 16'h0000 || (fire && pcnt_r == 16'h0001)) begin
              sim_pend_r <= 1'b0;
              if (pat_r == `PPS_PAT_CONT) begin
                dwell_r <= DWELL_LD;
                state_r <= S_DWELL;
              end else if (pat_r == `PPS_PAT_PATH) begin
                pd_addr_r <= pd_addr_r + 1'b1;
                state_r   <= S_PDRD;
              end else begin
                o_pos_done <= 1'b1;
                sb_addr_r  <= sb_addr_r + 1'b1;
                state_r    <= S_SBRD;
              end
            end
          end
          S_DWELL: begin
            if (dwell_r <= 8'h01) begin
              pd_addr_r <= pd_addr_r + 1'b1;
              state_r   <= S_PDRD;
            end else begin
              dwell_r <= dwell_r - 8'h01;
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/pps_drive_model.sv ***
// drive unit model that counts command pulses
`default_nettype none
module pps_drive_model (
  // clock
  input  wire logic        i_mclk,
  // command pulse and count clear
  input  wire logic        i_pulse,
  input  wire logic        i_clr,
  // pulses received so far
  output var  logic [15:0] o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // one count per high cycle; a stuck pulse line shows as a huge count
  always @(posedge i_mclk) begin
    if (i_clr) o_count <= 16'h0000;
    else if (i_pulse) o_count <= o_count + 16'h0001;
  end
endmodule
`default_nettype wire

// *** sim/pps_seq_asserts.sv ***
// assertion checker for the sequencer ports
`default_nettype none
module pps_seq_asserts #(
  parameter DIV = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // host side
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_hand_en,
  // drive side and status
  input wire logic o_pulse,
  input wire logic o_sim_start,
  input wire logic o_busy,
  input wire logic o_pos_done,
  input wire logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // port relations; the pulse gap holds for a DIV of 4 or more
  // ----------------------------------------------------------------
  a_stop_idle: assert property (i_stop && o_busy |=> !o_busy)
    else $error("busy after stop");
  a_stop_quiet: assert property (i_stop && o_busy && !i_hand_en |=> !o_pulse [*3])
    else $error("pulse after stop");
  a_pulse_gap: assert property (o_busy && o_pulse |=> !o_pulse [*3])
    else $error("pulses too close");
  a_done_once: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_sim_first: assert property (o_sim_start |-> o_pulse)
    else $error("sim start without pulse");
  a_start_take: assert property (!o_busy && i_start && !i_stop |=> o_busy)
    else $error("start not taken");
  a_idle_quiet: assert property (!o_busy && !$past(o_busy) && !i_hand_en
    && !$past(i_hand_en, 3) |-> !o_pulse)
    else $error("pulse while idle");
  a_posdone_once: assert property (o_pos_done |=> !o_pos_done)
    else $error("pos done too long");
endmodule
bind pps_seq pps_seq_asserts #(.DIV(DIV)) u_chk (
  .i_mclk, .i_rst_n, .i_start, .i_stop, .i_hand_en,
  .o_pulse, .o_sim_start, .o_busy, .o_pos_done, .o_done
);
`default_nettype wire

// *** sim/tb_positioning_program_sequencer.sv ***
// self-checking bench of the sequencer with an integer model
`default_nettype none
module tb_positioning_program_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 0, i_rst_n = 0, i_start = 0, i_stop = 0, i_hand_en = 0;
  logic        i_sb_we = 0, i_feed_start = 0, i_mpg_pulse = 0, clr = 0;
  logic [4:0]  i_start_blk = 0, i_sb_addr = 0;
  logic [15:0] i_sb_wdata = 0, cnt;
  logic [17:0] i_pd_wdata = 0;
  logic [7:0]  i_cond = 0, cnd, r = 8'h22;
  logic [3:0]  o_sim_axes;
  logic        o_pulse, o_sim_start, o_busy, o_pos_done, o_done;
  logic [15:0] sbt [0:31];
  logic [17:0] pdt [0:31];
  int          err_total = 0, checked = 0, c0, mpd, p0, npd = 0, nss = 0;
  // ----------------------------------------------------------------
  // clock, design and drive model
  // ----------------------------------------------------------------
  always #50 i_mclk = ~i_mclk;
  pps_seq #(.DIV(4)) dut (.i_mclk, .i_rst_n, .i_start, .i_start_blk, .i_stop, .i_hand_en,
    .i_sb_we, .i_sb_addr, .i_sb_wdata, .i_pd_we(i_sb_we), .i_pd_addr(i_sb_addr),
    .i_pd_wdata, .i_cond, .i_feed_start, .i_mpg_pulse, .o_pulse, .o_sim_start,
    .o_sim_axes, .o_busy, .o_pos_done, .o_done);
  pps_drive_model u_drv (.i_mclk, .i_pulse(o_pulse), .i_clr(clr), .o_count(cnt));
  // status strobes counted where they stand, so no one-cycle strobe goes unseen
  always @(posedge i_mclk) begin
    if (o_pos_done === 1'b1) npd++;
    if (o_sim_start === 1'b1) nss++;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // chain follows patterns until an independent entry ends it
  function automatic int chain(input int p);
    int n;
    n = 0;
    mpd++;
    do begin
      n += pdt[p][15:0];
      p = (p + 1) % 32;
    end while (pdt[(p + 31) % 32][17:16] != 2'h0);
    return n;
  endfunction
  // model walks the start block; the conditional loop exits on its first pass with the test's conditions
  function automatic int model(input int a);
    int n, lp, lc;
    logic [15:0] e;
    n = 0; lp = 0; lc = 0;
    while (sbt[a][15:13] != 3'h0) begin
      e = sbt[a];
      case (e[15:13])
        3'h2: if (cnd[e[2:0]]) n += chain(e[12:8]);
        3'h5: begin lp = a; lc = (e[7:0] > 1) ? e[7:0] : 1; end
        3'h6: begin lp = a; lc = 1; end
        3'h7: begin lc--; if (lc > 0) a = lp; end
        default: n += chain(e[12:8]);
      endcase
      a++;
    end
    return n;
  endfunction
  // block run; wt > 0 holds the wait condition false for wt cycles
  task run(input int a, input int wt);
    int t;
    @(negedge i_mclk); clr = 1; i_start = 1; i_start_blk = a[4:0];
    @(negedge i_mclk); clr = 0; i_start = 0; p0 = npd;
    if (wt > 0) begin
      repeat (wt) @(negedge i_mclk);
      check(cnt, 0);
      check(o_busy, 1);
      cnd = cnd | 8'h04; i_cond = cnd;
    end
    t = 0;
    while (o_done !== 1'b1 && t < 5000) begin @(negedge i_mclk); t++; end
    check(32'(t < 5000), 1);
    repeat (4) @(negedge i_mclk);
    mpd = 0;
    check(cnt, model(a));
    check(npd - p0, mpd);
    $display("block %0d done", a);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) begin sbt[i] = 0; pdt[i] = 0; end
    for (int i = 0; i < 6; i++) begin
      r = nx(r);
      pdt[i] = {(i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h0, 14'h0000, r[1:0] + 2'h1};
    end
    pdt[7] = 18'h0_0100;
    {sbt[0], sbt[1], sbt[2], sbt[3], sbt[4]} = {16'h2000, 16'h4301, 16'h4303, 16'hA602, 16'h2400};
    {sbt[5], sbt[6], sbt[7], sbt[8], sbt[9]} = {16'hE600, 16'hC600, 16'h2500, 16'hE600, 16'h0600};
    {sbt[10], sbt[12], sbt[14]} = {16'h6202, 16'h8205, 16'h2700};
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1;
    // table load, same address in both tables
    for (int i = 0; i < 32; i++) begin
      i_sb_we = 1; i_sb_addr = i[4:0]; i_sb_wdata = sbt[i]; i_pd_wdata = pdt[i];
      @(negedge i_mclk);
    end
    i_sb_we = 0;
    r = nx(r); cnd = (r & 8'hF0) | 8'h0D; i_cond = cnd;
    repeat (4) @(negedge i_mclk);
    run(0, 0);
    cnd = cnd & 8'hFB; i_cond = cnd;
    repeat (4) @(negedge i_mclk);
    run(10, 30);
    run(12, 0);
    check(o_sim_axes, 4'h5);
    check(nss, (pdt[2][15:0] != 0) ? 1 : 0);
    // stop in mid-entry
    clr = 1; i_start = 1; i_start_blk = 5'h0E;
    @(negedge i_mclk); clr = 0; i_start = 0;
    repeat (30) @(negedge i_mclk);
    i_stop = 1; @(negedge i_mclk); i_stop = 0; c0 = cnt;
    repeat (20) @(negedge i_mclk);
    check(o_busy, 0);
    check(cnt, c0);
    check(32'(c0 > 0), 1);
    $display("stop done");
    // constant feed held for 40 cycles
    clr = 1; @(negedge i_mclk); clr = 0; i_feed_start = 1;
    repeat (40) @(negedge i_mclk);
    i_feed_start = 0;
    repeat (10) @(negedge i_mclk); c0 = cnt;
    check(32'(cnt >= 8 && cnt <= 11), 1);
    repeat (10) @(negedge i_mclk);
    check(cnt, c0);
    $display("feed done");
    // handwheel: five generator pulses
    i_hand_en = 1; clr = 1; @(negedge i_mclk); clr = 0;
    repeat (5) begin
      i_mpg_pulse = 1; repeat (4) @(negedge i_mclk);
      i_mpg_pulse = 0; repeat (4) @(negedge i_mclk);
    end
    check(cnt, 5);
    i_hand_en = 0;
    $display("handwheel done");
    end_sim;
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #3_000_000;
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
